// [iip_intercept_unit.sv]
// Intercept priority decision and pause filter counter.
`timescale 1ns/1ns
`include "iip_defs.svh"

module iip_intercept_unit #(
   parameter int CNT_W = 16,
   parameter bit PAUSE_FILTER_EN = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM register slave
   input wire logic [`IIP_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Instruction request from the pipeline
   input wire iip_pkg::iip_req_type req,
   // Counter reload events
   input wire logic guestEnter,
   input wire logic reloadEvent,
   // Decision returned to the pipeline
   output iip_pkg::iip_resp_type resp,
   output logic [CNT_W-1:0] pauseCount
);

   // A counter wider than one bus word could not be read back.
   if (CNT_W < 1 || CNT_W > 32) begin : gBadWidth
      $error("CNT_W must be 1 to 32");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   iip_pkg::iip_bus_type busState;
   iip_pkg::iip_bus_type next_busState;
   logic [`IIP_CTRL_W-1:0] ctrl;
   logic [`IIP_CTRL_W-1:0] next_ctrl;
   logic [31:0] excMask;
   logic [31:0] next_excMask;
   logic [CNT_W-1:0] pfLimit;
   logic [CNT_W-1:0] next_pfLimit;
   logic [CNT_W-1:0] next_pauseCount;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   iip_pkg::iip_resp_type next_resp;
   logic [11:0] lastExit;
   logic [11:0] next_lastExit;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [31:0] featureWord;
   logic [31:0] pfLimitWide;
   logic [31:0] pauseCountWide;

   always_comb begin
      featureWord = 32'h0000_0000;
      featureWord[`IIP_FEAT_PAUSE_BIT] = PAUSE_FILTER_EN;
      pfLimitWide = 32'h0000_0000;
      pfLimitWide[CNT_W-1:0] = pfLimit;
      pauseCountWide = 32'h0000_0000;
      pauseCountWide[CNT_W-1:0] = pauseCount;
   end

   // ****************************************************************
   // Register bus
   // ****************************************************************
   // Every access takes exactly one wait cycle, so read data is always
   // captured from stable state one edge before the master takes it.
   logic [31:0] wordNew;

   always_comb begin
      next_busState = busState;
      next_waitrequest = 1'b1;
      next_readdata = readdata;
      next_ctrl = ctrl;
      next_excMask = excMask;
      next_pfLimit = pfLimit;
      wordNew = 32'h0000_0000;
      case (busState)
         iip_pkg::IIP_BUS_IDLE: begin
            if (read || write) begin
               next_busState = iip_pkg::IIP_BUS_ACK;
               next_waitrequest = 1'b0;
               next_readdata = 32'h0000_0000;
               if (read) begin
                  case (address)
                     `IIP_REG_CTRL: begin
                        next_readdata[`IIP_CTRL_W-1:0] = ctrl;
                     end
                     `IIP_REG_EXCMASK: next_readdata = excMask;
                     `IIP_REG_PFLIMIT: next_readdata = pfLimitWide;
                     `IIP_REG_PCOUNT: next_readdata = pauseCountWide;
                     `IIP_REG_FEATURE: next_readdata = featureWord;
                     `IIP_REG_EXITINFO: begin
                        next_readdata[11:0] = lastExit;
                     end
                     default: next_readdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         iip_pkg::IIP_BUS_ACK: begin
            next_busState = iip_pkg::IIP_BUS_IDLE;
            if (write) begin
               case (address)
                  `IIP_REG_CTRL: begin
                     wordNew = merge({19'h0, ctrl}, writedata, byteenable);
                     next_ctrl = wordNew[`IIP_CTRL_W-1:0];
                  end
                  `IIP_REG_EXCMASK: begin
                     next_excMask = merge(excMask, writedata, byteenable);
                  end
                  `IIP_REG_PFLIMIT: begin
                     wordNew = merge(pfLimitWide, writedata, byteenable);
                     next_pfLimit = wordNew[CNT_W-1:0];
                  end
                  default: wordNew = 32'h0000_0000;
               endcase
            end
         end
         default: next_busState = iip_pkg::IIP_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         busState <= iip_pkg::IIP_BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
         ctrl <= `IIP_CTRL_RST;
         excMask <= 32'h0000_0000;
         pfLimit <= '0;
      end else begin
         busState <= next_busState;
         waitrequest <= next_waitrequest;
         readdata <= next_readdata;
         ctrl <= next_ctrl;
         excMask <= next_excMask;
         pfLimit <= next_pfLimit;
      end
   end

   // ****************************************************************
   // Intercept decision
   // ****************************************************************
   logic icptEn;
   logic pauseHit;
   logic [11:0] instrExit;
   logic [15:0] ctrlWide;

   always_comb begin
      // Classes without an enable bit index zeros, never past the end.
      ctrlWide = 16'h0000;
      ctrlWide[`IIP_CTRL_W-1:0] = ctrl;
      icptEn = ctrlWide[req.instr];
      instrExit = `IIP_INSTR_EXIT_BASE + {8'h00, req.instr};
      pauseHit = 1'b0;
      next_pauseCount = pauseCount;
      next_lastExit = lastExit;
      next_resp = '0;
      next_resp.valid = req.valid;
      next_resp.outcome = iip_pkg::IIP_OUT_COMPLETE;
      next_resp.commit = 1'b1;
      next_resp.codeSel = req.codeSel;
      next_resp.codeIp = req.codeIp;
      if (req.valid) begin
         case (req.instr)
            iip_pkg::IIP_SOFT_INT: begin
               if (icptEn) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
               end else if (req.excPending) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = req.excVector;
               end else begin
                  next_resp.outcome = iip_pkg::IIP_OUT_DISPATCH;
                  next_resp.vector = req.swVector;
               end
            end
            iip_pkg::IIP_PAUSE: begin
               if (req.opcode == `IIP_PAUSE_OPCODE) begin
                  // Zero count or no filter exits.
                  pauseHit = !PAUSE_FILTER_EN || pauseCount == '0;
                  if (!pauseHit) begin
                     next_pauseCount = pauseCount - 1'b1;
                  end
                  if (pauseHit && icptEn) begin
                     next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
                  end
               end
            end
            iip_pkg::IIP_CACHE_DISCARD, iip_pkg::IIP_GUEST_ENTRY,
            iip_pkg::IIP_STATE_LOAD, iip_pkg::IIP_STATE_SAVE,
            iip_pkg::IIP_GIRQ_SET, iip_pkg::IIP_GIRQ_CLEAR,
            iip_pkg::IIP_SECURE_INIT: begin
               if (req.gpFault) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = `IIP_GP_VECTOR;
               end else if (icptEn) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
               end else if (req.excPending) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = req.excVector;
               end
            end
            iip_pkg::IIP_HALT, iip_pkg::IIP_PAGE_FLUSH,
            iip_pkg::IIP_TAGGED_FLUSH: begin
               if (req.gpFault) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = `IIP_GP_VECTOR;
               end else if (req.excPending) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = req.excVector;
               end else if (icptEn) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
               end
            end
            iip_pkg::IIP_HYPER_CALL: begin
               if (icptEn) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
               end else begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = `IIP_UD_VECTOR;
               end
            end
            default: begin
               if (req.gpFault) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = `IIP_GP_VECTOR;
               end else if (req.excPending) begin
                  next_resp.outcome = iip_pkg::IIP_OUT_FAULT;
                  next_resp.vector = req.excVector;
               end
            end
         endcase
         // Raised exceptions may themselves be intercepted by vector.
         // A software interrupt's own events bypass the mask.
         if (next_resp.outcome == iip_pkg::IIP_OUT_FAULT &&
             req.instr != iip_pkg::IIP_SOFT_INT &&
             next_resp.vector < `IIP_EXC_VEC_LIMIT &&
             excMask[next_resp.vector[4:0]]) begin
            next_resp.outcome = iip_pkg::IIP_OUT_EXIT;
            next_resp.exitCode = `IIP_EXC_EXIT_BASE +
                                 {4'h0, next_resp.vector};
         end else if (next_resp.outcome == iip_pkg::IIP_OUT_EXIT) begin
            next_resp.exitCode = instrExit;
         end
         // Exit or fault leaves no effect.
         if (next_resp.outcome == iip_pkg::IIP_OUT_EXIT ||
             next_resp.outcome == iip_pkg::IIP_OUT_FAULT) begin
            next_resp.commit = 1'b0;
         end
         if (next_resp.outcome == iip_pkg::IIP_OUT_EXIT) begin
            next_lastExit = next_resp.exitCode;
         end
      end
      // Reload from the limit copy.
      // The limit register itself is only ever written by software.
      // Counter changes, limit does not.
      if (guestEnter || reloadEvent) begin
         next_pauseCount = pfLimit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         resp <= '0;
         pauseCount <= '0;
         lastExit <= 12'h000;
      end else begin
         resp <= next_resp;
         pauseCount <= next_pauseCount;
         lastExit <= next_lastExit;
      end
   end

endmodule

// [iip_defs.svh]
// Constants for the instruction intercept priority unit.
//
// Overview of operation
// - Software interrupt intercept precedes all its exceptions.
// - Software interrupt exit reports its own location.
// - Vectors 0-31 from software interrupts never exception-exit.
// - Cache discard: protection fault before intercept.
// - Pause recognised; guest entry loads filter counter.
// - Pause decrements; exits when count underflows, enabled.
// - Filter limit never written back by hardware.
// - Management interrupt and similar reload pause counter.
// - Feature query bit ten advertises pause filtering.
// - No filter or zero limit: first pause exits.
// - Halt: all exceptions before intercept.
// - Page flushes: all exceptions before intercept.
// - Guest-control instructions: protection fault before intercept.
// - Hypervisor call intercept precedes all exceptions.
// - Unintercepted hypervisor call raises undefined opcode fault.
`ifndef IIP_DEFS_SVH
`define IIP_DEFS_SVH

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define IIP_ADDR_W 8
`define IIP_REG_CTRL 8'h00
`define IIP_REG_EXCMASK 8'h04
`define IIP_REG_PFLIMIT 8'h08
`define IIP_REG_PCOUNT 8'h0C
`define IIP_REG_FEATURE 8'h10
`define IIP_REG_EXITINFO 8'h14

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define IIP_CTRL_W 13
`define IIP_CTRL_RST 13'h0040
`define IIP_FEAT_PAUSE_BIT 10
`define IIP_EXC_EXIT_BASE 12'h040
`define IIP_INSTR_EXIT_BASE 12'h070
`define IIP_PAUSE_OPCODE 16'hF390
`define IIP_UD_VECTOR 8'h06
`define IIP_GP_VECTOR 8'h0D
`define IIP_EXC_VEC_LIMIT 8'h20

`endif

// [iip_pkg.sv]
// Types shared by the instruction intercept priority unit.
package iip_pkg;

   // Instruction class; the value is also the intercept enable bit.
   typedef enum logic [3:0] {
      IIP_SOFT_INT = 4'h0,
      IIP_CACHE_DISCARD = 4'h1,
      IIP_PAUSE = 4'h2,
      IIP_HALT = 4'h3,
      IIP_PAGE_FLUSH = 4'h4,
      IIP_TAGGED_FLUSH = 4'h5,
      IIP_GUEST_ENTRY = 4'h6,
      IIP_STATE_LOAD = 4'h7,
      IIP_STATE_SAVE = 4'h8,
      IIP_GIRQ_SET = 4'h9,
      IIP_GIRQ_CLEAR = 4'hA,
      IIP_SECURE_INIT = 4'hB,
      IIP_HYPER_CALL = 4'hC,
      IIP_OTHER = 4'hF
   } iip_instr_type;

   typedef enum logic [3:0] {
      IIP_OUT_COMPLETE = 4'h1,
      IIP_OUT_EXIT = 4'h2,
      IIP_OUT_FAULT = 4'h4,
      IIP_OUT_DISPATCH = 4'h8
   } iip_outcome_type;

   typedef struct packed {
      logic valid;
      iip_instr_type instr;
      logic [15:0] opcode;
      logic gpFault;
      logic excPending;
      logic [7:0] excVector;
      logic [7:0] swVector;
      logic [15:0] codeSel;
      logic [63:0] codeIp;
   } iip_req_type;

   typedef struct packed {
      logic valid;
      iip_outcome_type outcome;
      logic commit;
      logic [11:0] exitCode;
      logic [7:0] vector;
      logic [15:0] codeSel;
      logic [63:0] codeIp;
   } iip_resp_type;

   typedef enum logic [1:0] {
      IIP_BUS_IDLE = 2'b01,
      IIP_BUS_ACK = 2'b10
   } iip_bus_type;

endpackage

// [iip_assertions.sv]
// Port-level checks for the intercept priority unit.
`timescale 1ns/1ns
module iip_assertions #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register bus
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Pipeline side
   input wire iip_pkg::iip_req_type req,
   input wire logic guestEnter,
   input wire logic reloadEvent,
   input wire iip_pkg::iip_resp_type resp,
   input wire logic [CNT_W-1:0] pauseCount
);
   // Enables, mask and limit live in registers, so shadows follow writes.
   logic [12:0] ctrl;
   logic [12:0] next_ctrl;
   logic [31:0] excm;
   logic [31:0] next_excm;
   logic [31:0] lim;
   logic [31:0] next_lim;
   logic wrDone;
   logic [3:0] ins;
   logic [3:0] oc;
   logic pv;
   assign wrDone = write && !waitrequest;
   assign ins = req.instr;
   assign oc = resp.outcome;
   assign pv = req.valid && ins == 4'h2 && req.opcode == 16'hF390 &&
      !guestEnter && !reloadEvent;
   always_comb begin
      next_ctrl = ctrl;
      next_excm = excm;
      next_lim = lim;
      for (int i = 0; i < 4; i++) begin
         if (wrDone && byteenable[i] && address == 8'h04) begin
            next_excm[i*8 +: 8] = writedata[i*8 +: 8];
         end
         if (wrDone && byteenable[i] && address == 8'h08) begin
            next_lim[i*8 +: 8] = writedata[i*8 +: 8];
         end
      end
      if (wrDone && address == 8'h00) begin
         if (byteenable[0]) next_ctrl[7:0] = writedata[7:0];
         if (byteenable[1]) next_ctrl[12:8] = writedata[12:8];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl <= 13'h0040;
         excm <= 32'h0000_0000;
         lim <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         excm <= next_excm;
         lim <= next_lim;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   chk_resp_timing: assert property (req.valid |=> resp.valid)
      else $error("response missing after request");
   chk_exit_nocommit: assert property (
      resp.valid && oc inside {4'h2, 4'h4} |-> !resp.commit)
      else $error("exit or fault committed");
   chk_softint_first: assert property (
      req.valid && ins == 4'h0 && ctrl[0]
      |=> oc == 4'h2 && resp.exitCode == 12'h070)
      else $error("software interrupt intercept not first");
   chk_softint_loc: assert property (
      req.valid && ins == 4'h0 && ctrl[0]
      |=> resp.codeIp == $past(req.codeIp) &&
      resp.codeSel == $past(req.codeSel))
      else $error("wrong location reported");
   chk_softint_noexc: assert property (
      req.valid && ins == 4'h0 && !ctrl[0] |=> oc != 4'h2)
      else $error("software interrupt took exception exit");
   chk_gp_first: assert property (
      req.valid && req.gpFault && ins inside {4'h1, [4'h3:4'hB]}
      |=> ($past(excm[13]) ? (oc == 4'h2 && resp.exitCode == 12'h04D) :
      (oc == 4'h4 && resp.vector == 8'h0D)))
      else $error("protection fault not first");
   chk_hcall_first: assert property (
      req.valid && ins == 4'hC && ctrl[12]
      |=> oc == 4'h2 && resp.exitCode == 12'h07C)
      else $error("hypervisor call intercept not first");
   chk_hcall_ud: assert property (
      req.valid && ins == 4'hC && !ctrl[12]
      |=> ($past(excm[6]) ? (oc == 4'h2 && resp.exitCode == 12'h046) :
      (oc == 4'h4 && resp.vector == 8'h06)))
      else $error("hypervisor call without undefined fault");
   chk_pause_dec: assert property (
      pv && pauseCount != '0 |=> pauseCount == $past(pauseCount) - 1'b1)
      else $error("pause count not decremented");
   chk_pause_exit: assert property (
      pv && pauseCount == '0 && ctrl[2]
      |=> oc == 4'h2 && resp.exitCode == 12'h072 && pauseCount == '0)
      else $error("pause underflow without exit");
   chk_reload_count: assert property (
      guestEnter || reloadEvent
      |=> pauseCount == $past(lim[CNT_W-1:0]))
      else $error("pause counter not reloaded from limit");
endmodule

bind iip_intercept_unit iip_assertions #(.CNT_W(CNT_W)) chk_u (
   .clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
   .write(write), .byteenable(byteenable), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .req(req),
   .guestEnter(guestEnter), .reloadEvent(reloadEvent), .resp(resp),
   .pauseCount(pauseCount));

// [test_instruction_intercept_priority.sv]
// Directed bench for the intercept priority unit.
`timescale 1ns/1ns
module test_instruction_intercept_priority;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   iip_pkg::iip_req_type req = '0;
   logic guestEnter = 1'b0;
   logic reloadEvent = 1'b0;
   iip_pkg::iip_resp_type resp;
   iip_pkg::iip_resp_type rs;
   logic [15:0] pauseCount;
   logic [31:0] rd;
   int nFail = 0;
   int checkCount = 0;
   int k;

   always #5 clk_sys = ~clk_sys;

   iip_intercept_unit dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .req(req), .guestEnter(guestEnter),
      .reloadEvent(reloadEvent), .resp(resp), .pauseCount(pauseCount));

   task automatic print_verdict();
      $display("checks %0d errors %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         nFail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // The request stays up until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (waitrequest === 1'b0) break;
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // A hung access counts once; the run still ends in one place.
      if (i == 20) begin
         nFail++;
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic ev(input logic g);
      @(posedge clk_sys);
      guestEnter <= g;
      reloadEvent <= !g;
      @(posedge clk_sys);
      guestEnter <= 1'b0;
      reloadEvent <= 1'b0;
      #1;
   endtask

   task automatic ins(input logic [3:0] c, input logic [15:0] op,
      input logic gp, input logic [7:0] ev);
      @(posedge clk_sys);
      req.valid <= 1'b1;
      req.instr <= iip_pkg::iip_instr_type'(c);
      req.opcode <= op;
      req.gpFault <= gp;
      req.excPending <= (ev != 8'h00);
      req.excVector <= ev;
      req.swVector <= 8'h03;
      req.codeSel <= 16'h0008;
      req.codeIp <= 64'h1234;
      @(posedge clk_sys);
      req.valid <= 1'b0;
      #1 rs = resp;
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      rdc(8'h00, 32'h40);
      rdc(8'h04, 32'h0);
      rdc(8'h08, 32'h0);
      rdc(8'h0C, 32'h0);
      rdc(8'h20, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(rd & 32'h400, 32'h400);
      bus(1'b1, 8'h08, 32'h3);
      bus(1'b1, 8'h00, 32'h1FFF);
      ev(1'b1);
      rdc(8'h0C, 32'h3);
      for (k = 2; k >= 0; k--) begin
         ins(4'h2, 16'hF390, 1'b0, 8'h00);
         chk({rs.outcome, pauseCount}, {4'h1, k[15:0]});
      end
      ins(4'h2, 16'hF390, 1'b0, 8'h00);
      chk({rs.outcome, rs.exitCode}, 16'h2072);
      rdc(8'h14, 32'h72);
      rdc(8'h08, 32'h3);
      ev(1'b0);
      chk(pauseCount, 32'h3);
      ins(4'h2, 16'h9090, 1'b0, 8'h00);
      chk(pauseCount, 32'h3);
      bus(1'b1, 8'h08, 32'h0);
      ev(1'b1);
      ins(4'h2, 16'hF390, 1'b0, 8'h00);
      chk({rs.outcome, rs.exitCode}, 16'h2072);
      for (k = 1; k < 12; k++) begin
         if (k == 2) continue;
         ins(k[3:0], 16'h0, 1'b1, 8'h00);
         chk({rs.outcome, rs.vector}, 12'h40D);
         ins(k[3:0], 16'h0, 1'b0, 8'h00);
         chk(rs.exitCode, 12'h070 + k);
      end
      ins(4'hF, 16'h0, 1'b1, 8'h00);
      chk({rs.commit, rs.outcome, rs.vector}, 13'h040D);
      ins(4'hF, 16'h0, 1'b0, 8'h00);
      chk({rs.commit, rs.outcome, rs.vector}, 13'h1100);
      ins(4'h3, 16'h0, 1'b0, 8'h0E);
      chk({rs.outcome, rs.vector}, 12'h40E);
      ins(4'h0, 16'h0, 1'b0, 8'h0E);
      chk({rs.outcome, rs.exitCode}, 16'h2070);
      chk({rs.codeSel, rs.codeIp[15:0]}, 32'h00081234);
      ins(4'hC, 16'h0, 1'b0, 8'h0D);
      chk({rs.outcome, rs.exitCode}, 16'h207C);
      bus(1'b1, 8'h00, 32'h0FFE);
      ins(4'hC, 16'h0, 1'b0, 8'h00);
      chk({rs.outcome, rs.vector}, 12'h406);
      bus(1'b1, 8'h04, 32'hFFFFFFFF);
      ins(4'h0, 16'h0, 1'b0, 8'h00);
      chk({rs.outcome, rs.vector}, 12'h803);
      ins(4'h0, 16'h0, 1'b0, 8'h0E);
      chk({rs.outcome, rs.vector}, 12'h40E);
      ins(4'h3, 16'h0, 1'b0, 8'h0E);
      chk({rs.outcome, rs.exitCode}, 16'h204E);
      print_verdict();
   end
endmodule
